/* design/ishi_cfg_mem.sv */
`timescale 1ns/10ps
// ==========================================================================
// Working memory and non-volatile store, one word copied per cycle
// ==========================================================================
module ishi_cfg_mem #(
	parameter int DEPTH = 16,
	parameter int DW = 32
)(
	input wire logic aclk,
	ishi_mem_if.mem mif
);
	logic [DW-1:0] work_r [DEPTH];
	logic [DW-1:0] store_r [DEPTH];

	always_ff @(posedge aclk) begin
		if (mif.x_en && !mif.x_to_store) begin
			work_r[mif.x_idx] <= store_r[mif.x_idx];
		end else if (mif.h_we) begin
			work_r[mif.h_addr] <= mif.h_wdata;
		end
	end

	always_ff @(posedge aclk) begin
		if (mif.x_en && mif.x_to_store) begin
			store_r[mif.x_idx] <= work_r[mif.x_idx];
		end
	end

	always_ff @(posedge aclk) begin
		mif.h_rdata <= work_r[mif.h_addr];
	end
endmodule // ishi_cfg_mem

/* design/ishi_mem_if.sv */
`timescale 1ns/10ps
// ==========================================================================
// Configuration memory access bundle
// ==========================================================================
interface ishi_mem_if #(parameter int AW = 4, parameter int DW = 32);
	logic [AW-1:0] h_addr;
	logic h_we;
	logic [DW-1:0] h_wdata;
	logic [DW-1:0] h_rdata;
	logic x_en;
	logic x_to_store;
	logic [AW-1:0] x_idx;
	modport ctl (output h_addr, h_we, h_wdata, x_en, x_to_store, x_idx, input h_rdata);
	modport mem (input h_addr, h_we, h_wdata, x_en, x_to_store, x_idx, output h_rdata);
endinterface

/* design/ishi_pkg.sv */
// ==========================================================================
// Shared constants
// ==========================================================================
package ishi_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int T_ANA_MS = 100;
	localparam int T_DIG_MS = 100;
	localparam int T_STORE_MS = 2600;
	localparam int T_LOAD_MS = 20;
	localparam int ANA_CYC_DEF = CYC_PER_MS * T_ANA_MS;
	localparam int DIG_CYC_DEF = CYC_PER_MS * T_DIG_MS;
	localparam int STORE_CYC_DEF = CYC_PER_MS * T_STORE_MS;
	localparam int LOAD_CYC_DEF = CYC_PER_MS * T_LOAD_MS;
	localparam int HB_LIMIT_DEF = 64;
	localparam int MEM_DEPTH = 16;
	localparam int MEM_WIDTH = 32;
	localparam int AXI_AW = 8;
	// Register byte offsets
	localparam logic [7:0] OFS_CMD_STATUS = 8'h00;
	localparam logic [7:0] OFS_CTRL = 8'h04;
	localparam logic [7:0] OFS_GCFG = 8'h08;
	localparam logic [7:0] OFS_MUX_DLY = 8'h0c;
	localparam logic [7:0] OFS_MEM_ADDR = 8'h10;
	localparam logic [7:0] OFS_MEM_DATA = 8'h14;
	localparam logic [7:0] OFS_LINK_STAT = 8'h18;
	// Field positions
	localparam int CTRL_STORE_BIT = 0;
	localparam int CTRL_LOAD_BIT = 1;
	// Command status, rejection and response codes, reset values and state types
	localparam logic [7:0] CS_NONE = 8'h00;
	localparam logic [7:0] CS_INIT = 8'h80;
	localparam logic [7:0] CS_DONE = 8'h40;
	localparam logic [15:0] MUX_DLY_RST = 16'h0001;
	localparam logic [1:0] REJ_BOTH = 2'h0;
	localparam logic [1:0] REJ_60 = 2'h1;
	localparam logic [1:0] REJ_50 = 2'h2;
	localparam logic [1:0] REJ_RST = REJ_BOTH;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	typedef enum logic [1:0] {ST_OFF, ST_ANA, ST_DIG, ST_RDY} ishi_st_t;
	typedef enum logic [1:0] {XF_IDLE, XF_STORE, XF_LOAD} ishi_xf_t;
endpackage

/* design/ishi_top.sv */
`timescale 1ns/10ps
module ishi_top import ishi_pkg::*; #(
	parameter int ANA_CYC = ANA_CYC_DEF,
	parameter int DIG_CYC = DIG_CYC_DEF,
	parameter int STORE_CYC = STORE_CYC_DEF,
	parameter int LOAD_CYC = LOAD_CYC_DEF,
	parameter int HB_LIMIT = HB_LIMIT_DEF,
	parameter int DEPTH = MEM_DEPTH
)(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic isolation_enable,
	input wire logic serial_output_enable_n,
	input wire logic sdo_data,
	output logic sdo_out,
	output logic sdo_oe,
	output logic barrier_out,
	output logic barrier_oe,
	output logic iso_power_en,
	input wire logic link_clk,
	input wire logic barrier_in,
	input wire logic conv_start,
	input wire logic conv_finish,
	output logic conv_done_out
);
	localparam int AW = $clog2(DEPTH);

	// ======================================================================
	// Pin synchronisers and logic reset
	// ======================================================================
	logic en_s1_r, en_s2_r, soe_s1_r, soe_s2_r, lrst;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			en_s1_r <= 1'b0;
			en_s2_r <= 1'b0;
			soe_s1_r <= 1'b1;
			soe_s2_r <= 1'b1;
		end else begin
			en_s1_r <= isolation_enable;
			en_s2_r <= en_s1_r;
			soe_s1_r <= serial_output_enable_n;
			soe_s2_r <= soe_s1_r;
		end
	end
	assign lrst = !aresetn || !en_s2_r;

	// ======================================================================
	// Isolated-side domain
	// ======================================================================
	logic ien_s1_r, ien_s2_r, bin_s1_r, bin_s2_r, hb_r, cv_tg_r, conv_done_r;
	always_ff @(posedge link_clk) begin
		ien_s1_r <= isolation_enable;
		ien_s2_r <= ien_s1_r;
		bin_s1_r <= barrier_in;
		bin_s2_r <= bin_s1_r;
	end
	always_ff @(posedge link_clk) begin
		if (!ien_s2_r) begin
			hb_r <= 1'b0;
			cv_tg_r <= 1'b0;
			conv_done_r <= 1'b0;
		end else begin
			hb_r <= !hb_r;
			if (conv_finish) begin
				cv_tg_r <= !cv_tg_r;
				conv_done_r <= 1'b1;
			end else if (conv_start) begin
				conv_done_r <= 1'b0;
			end
		end
	end
	assign conv_done_out = conv_done_r;

	a_conv_done_rise: assert property (@(posedge link_clk) disable iff (!ien_s2_r)
		conv_finish |=> conv_done_r ##0 $past(cv_tg_r) != cv_tg_r)
		else $error("conversion finish did not raise done");

	// ======================================================================
	// Crossings into the bus domain
	// ======================================================================
	logic bar_a1_r, bar_a2_r, hb_a1_r, hb_a2_r, hb_a3_r, cv_a1_r, cv_a2_r, cv_a3_r;
	always_ff @(posedge aclk) begin
		if (lrst) begin
			{bar_a1_r, bar_a2_r, hb_a1_r, hb_a2_r, hb_a3_r} <= 5'h00;
			{cv_a1_r, cv_a2_r, cv_a3_r} <= 3'h0;
		end else begin
			bar_a1_r <= bin_s2_r;
			bar_a2_r <= bar_a1_r;
			hb_a1_r <= hb_r;
			hb_a2_r <= hb_a1_r;
			hb_a3_r <= hb_a2_r;
			cv_a1_r <= cv_tg_r;
			cv_a2_r <= cv_a1_r;
			cv_a3_r <= cv_a2_r;
		end
	end

	logic [7:0] conv_cnt_r;
	always_ff @(posedge aclk) begin
		if (lrst) begin
			conv_cnt_r <= 8'h00;
		end else if (cv_a2_r != cv_a3_r) begin
			conv_cnt_r <= conv_cnt_r + 8'h01;
		end
	end

	// ======================================================================
	// Start-up sequence
	// ======================================================================
	ishi_st_t st_r;
	logic [31:0] cnt_r;
	logic [7:0] cmd_status;
	always_ff @(posedge aclk) begin
		if (lrst) begin
			st_r <= ST_OFF;
			cnt_r <= 32'h0;
		end else begin
			unique case (st_r)
				ST_OFF: begin
					st_r <= ST_ANA;
					cnt_r <= 32'h0;
				end
				ST_ANA: begin
					if (cnt_r == 32'(ANA_CYC - 1)) begin
						st_r <= ST_DIG;
						cnt_r <= 32'h0;
					end else begin
						cnt_r <= cnt_r + 32'h1;
					end
				end
				ST_DIG: begin
					if (cnt_r == 32'(DIG_CYC - 1)) begin
						st_r <= ST_RDY;
						cnt_r <= 32'h0;
					end else begin
						cnt_r <= cnt_r + 32'h1;
					end
				end
				ST_RDY: begin
					cnt_r <= 32'h0;
				end
			endcase
		end
	end

	always_comb begin
		unique case (st_r)
			ST_DIG: cmd_status = CS_INIT;
			ST_RDY: cmd_status = CS_DONE;
			default: cmd_status = CS_NONE;
		endcase
	end

	a_dig_follows_ana: assert property (@(posedge aclk) disable iff (lrst)
		(st_r == ST_ANA && cnt_r == 32'(ANA_CYC - 1)) |=> (st_r == ST_DIG && cnt_r == 32'h0))
		else $error("digital init did not follow power-up");
	a_status_init_val: assert property (@(posedge aclk) disable iff (lrst)
		(st_r == ST_ANA && cnt_r == 32'(ANA_CYC - 1)) |=> cmd_status == 8'h80)
		else $error("status not 0x80 at init start");
	a_status_done_val: assert property (@(posedge aclk) disable iff (lrst)
		(st_r == ST_DIG && cnt_r == 32'(DIG_CYC - 1)) |=> cmd_status == 8'h40)
		else $error("status not 0x40 at init end");
	a_startup_bounds: assert property (@(posedge aclk) disable iff (lrst)
		(st_r == ST_ANA || st_r == ST_DIG) |-> cnt_r < 32'(DIG_CYC > ANA_CYC ? DIG_CYC : ANA_CYC))
		else $error("start-up phase too long");

	// ======================================================================
	// Barrier health and pin drivers
	// ======================================================================
	logic [15:0] hb_cnt_r;
	logic comm_fail_r, sdo_r, sdo_oe_r, bar_r, bar_oe_r, pwr_r, link_up;
	assign link_up = (st_r == ST_DIG || st_r == ST_RDY);
	always_ff @(posedge aclk) begin
		if (lrst) begin
			hb_cnt_r <= 16'h0;
			comm_fail_r <= 1'b0;
		end else if (hb_a2_r != hb_a3_r || !link_up) begin
			hb_cnt_r <= 16'h0;
			comm_fail_r <= 1'b0;
		end else if (hb_cnt_r == 16'(HB_LIMIT - 1)) begin
			comm_fail_r <= 1'b1;
		end else begin
			hb_cnt_r <= hb_cnt_r + 16'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (lrst) begin
			sdo_r <= 1'b0;
			sdo_oe_r <= 1'b0;
			bar_r <= 1'b0;
			bar_oe_r <= 1'b0;
		end else begin
			sdo_oe_r <= link_up && !comm_fail_r && !soe_s2_r;
			sdo_r <= sdo_data;
			bar_oe_r <= link_up && !comm_fail_r;
			bar_r <= bar_a2_r;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pwr_r <= 1'b0;
		end else begin
			pwr_r <= en_s2_r;
		end
	end
	assign sdo_out = sdo_r;
	assign sdo_oe = sdo_oe_r;
	assign barrier_out = bar_r;
	assign barrier_oe = bar_oe_r;
	assign iso_power_en = pwr_r;

	a_sdo_float: assert property (@(posedge aclk) disable iff (!aresetn)
		soe_s2_r |=> !sdo_oe)
		else $error("serial output driven while disabled");
	a_off_float: assert property (@(posedge aclk) disable iff (!aresetn)
		!en_s2_r |=> (!sdo_oe && !barrier_oe && !iso_power_en && cmd_status == 8'h00))
		else $error("outputs active while enable low");
	a_power_follow: assert property (@(posedge aclk) disable iff (!aresetn)
		en_s2_r |=> iso_power_en)
		else $error("isolated side not powered");
	a_fail_float: assert property (@(posedge aclk) disable iff (lrst)
		comm_fail_r |=> (!sdo_oe && !barrier_oe))
		else $error("outputs driven on barrier failure");
	a_barrier_copy: assert property (@(posedge aclk) disable iff (lrst)
		(bar_oe_r && $stable(bar_a2_r)) |=> barrier_out == $past(bar_a2_r, 2))
		else $error("barrier output does not follow input");

	// ======================================================================
	// Configuration memory and transfers
	// ======================================================================
	ishi_mem_if #(.AW(AW), .DW(MEM_WIDTH)) mif ();
	ishi_cfg_mem #(.DEPTH(DEPTH), .DW(MEM_WIDTH)) u_mem (
		.aclk(aclk),
		.mif(mif)
	);

	ishi_xf_t xf_r;
	logic [31:0] xcnt_r, xlim;
	logic [AW-1:0] mem_addr_r;
	logic store_req, load_req, mem_we;
	logic [31:0] wr_data;
	assign xlim = (xf_r == XF_STORE) ? 32'(STORE_CYC) : 32'(LOAD_CYC);
	always_ff @(posedge aclk) begin
		if (lrst) begin
			xf_r <= XF_IDLE;
			xcnt_r <= 32'h0;
		end else begin
			unique case (xf_r)
				XF_IDLE: begin
					xcnt_r <= 32'h0;
					if (store_req) begin
						xf_r <= XF_STORE;
					end else if (load_req) begin
						xf_r <= XF_LOAD;
					end
				end
				XF_STORE, XF_LOAD: begin
					if (xcnt_r == xlim - 32'h1) begin
						xf_r <= XF_IDLE;
					end
					xcnt_r <= xcnt_r + 32'h1;
				end
				default: xf_r <= XF_IDLE;
			endcase
		end
	end
	assign mif.x_en = (xf_r != XF_IDLE) && (xcnt_r < 32'(DEPTH));
	assign mif.x_to_store = (xf_r == XF_STORE);
	assign mif.x_idx = xcnt_r[AW-1:0];
	assign mif.h_addr = mem_addr_r;
	assign mif.h_we = mem_we;
	assign mif.h_wdata = wr_data;

	a_store_time: assert property (@(posedge aclk) disable iff (lrst)
		(xf_r == XF_STORE) |-> xcnt_r < 32'(STORE_CYC))
		else $error("store transfer too long");
	a_load_time: assert property (@(posedge aclk) disable iff (lrst)
		(xf_r == XF_LOAD) |-> xcnt_r < 32'(LOAD_CYC))
		else $error("reload transfer too long");

	// ======================================================================
	// AXI4-Lite slave
	// ======================================================================
	logic aw_v_r, w_v_r, bvalid_r, rvalid_r, do_wr;
	logic [AXI_AW-1:0] aw_addr_r;
	logic [31:0] w_data_r, rdata_r, rd_data;
	logic [3:0] w_strb_r;
	logic [1:0] bresp_r, rresp_r, rd_resp;
	logic [1:0] gcfg_r;
	logic [15:0] mux_dly_r;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return res;
	endfunction

	assign s_axi_awready = !aw_v_r && !bvalid_r;
	assign s_axi_wready = !w_v_r && !bvalid_r;
	assign s_axi_arready = !rvalid_r;
	assign do_wr = aw_v_r && w_v_r;
	assign wr_data = merge(mif.h_rdata, w_data_r, w_strb_r);
	assign mem_we = do_wr && !lrst && aw_addr_r == OFS_MEM_DATA && xf_r == XF_IDLE;
	assign store_req = do_wr && aw_addr_r == OFS_CTRL && w_strb_r[0] && w_data_r[CTRL_STORE_BIT] && st_r == ST_RDY;
	assign load_req = do_wr && aw_addr_r == OFS_CTRL && w_strb_r[0] && w_data_r[CTRL_LOAD_BIT] && st_r == ST_RDY;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_v_r <= 1'b0;
			w_v_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0;
			w_strb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_v_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_v_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_v_r <= 1'b0;
				w_v_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= (aw_addr_r[7:2] > OFS_LINK_STAT[7:2] || aw_addr_r[1:0] != 2'h0) ? RESP_DECERR : RESP_OKAY;
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (lrst) begin
			gcfg_r <= REJ_RST;
			mux_dly_r <= MUX_DLY_RST;
			mem_addr_r <= '0;
		end else if (do_wr && aw_addr_r == OFS_GCFG && w_strb_r[0]) begin
			gcfg_r <= w_data_r[1:0];
		end else if (do_wr && aw_addr_r == OFS_MUX_DLY) begin
			mux_dly_r <= 16'(merge({16'h0, mux_dly_r}, w_data_r, w_strb_r));
		end else if (do_wr && aw_addr_r == OFS_MEM_ADDR && w_strb_r[0]) begin
			mem_addr_r <= w_data_r[AW-1:0];
		end
	end

	a_config_defaults: assert property (@(posedge aclk) disable iff (!aresetn)
		$past(lrst) |-> (mux_dly_r == 16'h0001 && gcfg_r == 2'h0))
		else $error("configuration defaults wrong");

	always_comb begin
		rd_data = 32'h0;
		rd_resp = RESP_OKAY;
		unique case (s_axi_araddr)
			OFS_CMD_STATUS: begin
				rd_data = {24'h0, cmd_status};
				if (st_r == ST_ANA || st_r == ST_OFF) begin
					rd_resp = RESP_SLVERR;
				end
			end
			OFS_CTRL: rd_data = {30'h0, xf_r == XF_LOAD, xf_r == XF_STORE};
			OFS_GCFG: rd_data = {30'h0, gcfg_r};
			OFS_MUX_DLY: rd_data = {16'h0, mux_dly_r};
			OFS_MEM_ADDR: rd_data = 32'(mem_addr_r);
			OFS_MEM_DATA: rd_data = mif.h_rdata;
			OFS_LINK_STAT: rd_data = {16'h0, conv_cnt_r, 4'h0, bar_a2_r, comm_fail_r, pwr_r, en_s2_r};
			default: rd_resp = RESP_DECERR;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0;
			rresp_r <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_data;
			rresp_r <= rd_resp;
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	a_status_hidden: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00 && st_r == ST_ANA)
		|=> (s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0))
		else $error("status readable during power-up");

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
endmodule // ishi_top

/* dv/ishi_iso_model.sv */
`timescale 1ns/10ps
// ==========================================================================
// Isolated-side converter and barrier input
// ==========================================================================
module ishi_iso_model (
	input wire logic link_clk,
	input wire logic conv_done_out,
	input wire logic loop_en,
	input wire logic level,
	output logic barrier_in,
	output logic conv_start,
	output logic conv_finish
);
	initial begin
		conv_start = 1'b0;
		conv_finish = 1'b0;
	end
	// Board loop of the done flag into the barrier input
	assign barrier_in = loop_en ? conv_done_out : level;
	task automatic convert(input int busy);
		@(posedge link_clk);
		conv_start <= 1'b1;
		@(posedge link_clk);
		conv_start <= 1'b0;
		repeat (busy) @(posedge link_clk);
		conv_finish <= 1'b1;
		@(posedge link_clk);
		conv_finish <= 1'b0;
	endtask
endmodule // ishi_iso_model

/* dv/ishi_tb_top.sv */
`timescale 1ns/10ps
// ==========================================================================
// Testbench top
// ==========================================================================
module ishi_tb_top import ishi_pkg::*; ;
	localparam int ANA = 200;
	localparam int DIG = 200;
	localparam int STO = 400;
	localparam int LDC = 100;
	typedef struct {logic wr; logic [7:0] a; logic [31:0] v; logic [31:0] e; logic [1:0] rsp;} ishi_row_t;
	logic aclk = 1'b0;
	logic lclk = 1'b0;
	logic link_run = 1'b1;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	// Enable starts low so the isolated-side logic is reset before first use
	logic iso_en = 1'b0;
	logic serial_output_enable_n_n = 1'b0;
	logic sdo_data = 1'b0, loop_en = 1'b0, level = 1'b0;
	logic sdo_out, sdo_oe, barrier_out, barrier_oe, iso_power_en, barrier_in, conv_start, conv_finish, conv_done;
	int err_total = 0;
	int tests_run = 0;
	logic [31:0] d, d0;
	logic [1:0] r;
	int c;
	ishi_row_t rows [10] = '{
		'{1'b0, OFS_CMD_STATUS, 32'h0, 32'(CS_DONE), RESP_OKAY},
		'{1'b0, OFS_MUX_DLY, 32'h0, 32'(MUX_DLY_RST), RESP_OKAY},
		'{1'b0, OFS_GCFG, 32'h0, 32'(REJ_RST), RESP_OKAY},
		'{1'b1, OFS_GCFG, 32'(REJ_60), 32'h0, RESP_OKAY},
		'{1'b0, OFS_GCFG, 32'h0, 32'(REJ_60), RESP_OKAY},
		'{1'b1, OFS_GCFG, 32'(REJ_50), 32'h0, RESP_OKAY},
		'{1'b0, OFS_GCFG, 32'h0, 32'(REJ_50), RESP_OKAY},
		'{1'b0, 8'h1c, 32'h0, 32'h0, RESP_DECERR},
		'{1'b0, 8'h02, 32'h0, 32'h0, RESP_DECERR},
		'{1'b1, 8'h20, 32'h5, 32'h0, RESP_DECERR}};

	always #5 aclk = ~aclk;
	initial begin
		#1.3;
		forever #32 if (link_run) lclk = ~lclk;
	end

	ishi_top #(.ANA_CYC(ANA), .DIG_CYC(DIG), .STORE_CYC(STO), .LOAD_CYC(LDC), .HB_LIMIT(HB_LIMIT_DEF),
		.DEPTH(MEM_DEPTH)) i_ishi_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.isolation_enable(iso_en), .serial_output_enable_n(serial_output_enable_n_n), .sdo_data(sdo_data), .sdo_out(sdo_out),
		.sdo_oe(sdo_oe), .barrier_out(barrier_out), .barrier_oe(barrier_oe), .iso_power_en(iso_power_en),
		.link_clk(lclk), .barrier_in(barrier_in), .conv_start(conv_start), .conv_finish(conv_finish),
		.conv_done_out(conv_done));
	ishi_iso_model i_ishi_iso_model (.link_clk(lclk), .conv_done_out(conv_done), .loop_en(loop_en),
		.level(level), .barrier_in(barrier_in), .conv_start(conv_start), .conv_finish(conv_finish));

	// ==========================================================================
	// Bus tasks and checks
	// ==========================================================================
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			err_total++;
			$display("Error at %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		do @(posedge aclk); while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		v = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask
	// Polls until the masked word matches; returns elapsed cycles
	task automatic wait_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] w, output int cyc);
		realtime t0;
		t0 = $realtime;
		do axr(a, d, r); while ((d & m) !== w);
		cyc = int'(($realtime - t0) / 10.0);
	endtask
	task automatic summarize();
		if (err_total == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		#200000;
		err_total++;
		summarize();
	end

	// ==========================================================================
	// Main sequence
	// ==========================================================================
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		iso_en <= 1'b1;
		axr(OFS_CMD_STATUS, d, r);
		chk(32'(r), 32'(RESP_SLVERR));
		chk(d, 32'h0);
		wait_rd(OFS_CMD_STATUS, 32'hff, 32'(CS_INIT), c);
		chk(32'(c >= ANA - 8 && c <= ANA + 12), 32'h1);
		wait_rd(OFS_CMD_STATUS, 32'hff, 32'(CS_DONE), c);
		chk(32'(c >= DIG - 8 && c <= DIG + 8), 32'h1);
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				axw(rows[i].a, rows[i].v, r);
			end else begin
				axr(rows[i].a, d, r);
				if (rows[i].rsp == RESP_OKAY) chk(d, rows[i].e);
			end
			chk(32'(r), 32'(rows[i].rsp));
		end
		axw(OFS_MEM_ADDR, 32'h3, r);
		axw(OFS_MEM_DATA, 32'h1234abcd, r);
		axw(OFS_CTRL, 32'h1, r);
		axr(OFS_CTRL, d, r);
		chk(d & 32'h3, 32'h1);
		wait_rd(OFS_CTRL, 32'h1, 32'h0, c);
		chk(32'(c >= STO - 12 && c <= STO), 32'h1);
		axw(OFS_MEM_DATA, 32'h0, r);
		axw(OFS_CTRL, 32'h2, r);
		axr(OFS_CTRL, d, r);
		chk(d & 32'h3, 32'h2);
		wait_rd(OFS_CTRL, 32'h2, 32'h0, c);
		chk(32'(c >= LDC - 12 && c <= LDC), 32'h1);
		axr(OFS_MEM_DATA, d, r);
		chk(d, 32'h1234abcd);
		sdo_data <= 1'b1;
		repeat (6) @(posedge aclk);
		chk(32'({sdo_oe, sdo_out}), 32'h3);
		// Serial bits held 34 cycles each, a bit rate under 3 MHz
		for (int b = 0; b < 4; b++) begin
			sdo_data <= b[0];
			repeat (34) @(posedge aclk);
			chk(32'({sdo_oe, sdo_out}), 32'({1'b1, b[0]}));
		end
		serial_output_enable_n_n <= 1'b1;
		repeat (6) @(posedge aclk);
		chk(32'(sdo_oe), 32'h0);
		serial_output_enable_n_n <= 1'b0;
		for (int v = 0; v < 2; v++) begin
			level <= v[0];
			repeat (25) @(posedge aclk);
			chk(32'({barrier_oe, barrier_out}), 32'(2 + v));
		end
		axr(OFS_LINK_STAT, d0, r);
		level <= 1'b0;
		loop_en <= 1'b1;
		i_ishi_iso_model.convert(2);
		#1;
		chk(32'(conv_done), 32'h1);
		repeat (25) @(posedge aclk);
		chk(32'(barrier_out), 32'h1);
		axr(OFS_LINK_STAT, d, r);
		chk(32'(d[15:8]), 32'(d0[15:8] + 8'h01));
		loop_en <= 1'b0;
		link_run = 1'b0;
		repeat (100) @(posedge aclk);
		chk(32'({sdo_oe, barrier_oe}), 32'h0);
		axr(OFS_LINK_STAT, d, r);
		chk(32'(d[2]), 32'h1);
		link_run = 1'b1;
		repeat (100) @(posedge aclk);
		chk(32'({sdo_oe, barrier_oe}), 32'h3);
		axw(OFS_GCFG, 32'(REJ_50), r);
		iso_en <= 1'b0;
		repeat (10) @(posedge aclk);
		chk(32'({iso_power_en, sdo_oe, barrier_oe}), 32'h0);
		axr(OFS_CMD_STATUS, d, r);
		chk(32'(r), 32'(RESP_SLVERR));
		iso_en <= 1'b1;
		repeat (6) @(posedge aclk);
		chk(32'(iso_power_en), 32'h1);
		wait_rd(OFS_CMD_STATUS, 32'hff, 32'(CS_DONE), c);
		repeat (25) @(posedge aclk);
		chk(32'({sdo_oe, barrier_oe}), 32'h3);
		axr(OFS_LINK_STAT, d, r);
		chk(d & 32'h3, 32'h3);
		axr(OFS_GCFG, d, r);
		chk(d & 32'h3, 32'(REJ_RST));
		summarize();
	end
endmodule // ishi_tb_top
